// [verilog/sfp_pkg.sv]
// Purpose: shared constants and types for the serial flash pin-function link
// Assumes: 25 MHz system clock on both ends
// Notes:   opcodes, apb map and timings are local choices of this block
package sfp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int WRITE_TIME_NS = 640;
  localparam int WRITE_CYC = (WRITE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int WCW = $clog2(WRITE_CYC + 1);
  localparam int SCK_HALF_NS = 320;
  localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_NS;

  // ----------------------------------------------------------------
  // link opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_RD_STATUS = 8'h05;
  localparam logic [7:0] OPC_RD_STATUS_DUAL = 8'h3b;
  localparam logic [7:0] OPC_RD_STATUS_QUAD = 8'h6b;
  localparam logic [7:0] OPC_WR_STATUS = 8'h01;
  localparam logic [7:0] OPC_WR_FUNC = 8'h42;
  localparam logic [7:0] OPC_WR_RDPARAM = 8'hc0;
  localparam logic [7:0] OPC_QPI_ENTER = 8'h35;
  localparam logic [7:0] OPC_QPI_EXIT = 8'hf5;

  // ----------------------------------------------------------------
  // device register fields and reset values
  // ----------------------------------------------------------------
  localparam int ST_GUARD = 7;
  localparam int ST_QUAD = 6;
  localparam int ST_PROT_LO = 2;
  localparam int ST_BUSY = 0;
  localparam int FN_DED_RST_DIS = 0;
  localparam int RP_PAUSE_RESTART = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] FUNC_RST = 8'h00;
  localparam logic [7:0] RDPARAM_RST = 8'h00;

  // ----------------------------------------------------------------
  // controller apb map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam int CMD_OPC_LO = 0;
  localparam int CMD_WD_LO = 8;
  localparam int CMD_KIND_LO = 16;
  localparam int CMD_RDW_LO = 18;
  localparam int CMD_QPI = 20;
  localparam logic [1:0] KIND_OPC = 2'h0;
  localparam logic [1:0] KIND_WR = 2'h1;
  localparam logic [1:0] KIND_RD = 2'h2;
  localparam logic [1:0] LN_1 = 2'h0;
  localparam logic [1:0] LN_2 = 2'h1;
  localparam logic [1:0] LN_4 = 2'h2;
  localparam int CTL_CPOL = 0;
  localparam int CTL_WP = 1;
  localparam int CTL_PAUSE = 2;
  localparam int CTL_RESTART = 3;
  localparam logic [3:0] CTRL_RST = 4'he;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RX_LO = 8;

  typedef enum logic [2:0] {DV_IDLE, DV_OPC, DV_WDATA, DV_READ, DV_DROP} sfp_dev_state_e;
  typedef enum logic {HS_IDLE, HS_RUN} sfp_host_state_e;

endpackage : sfp_pkg

// [verilog/sfp_if.sv]
// Purpose: pin bundle between controller and flash device
// Assumes: each data line is pulled up when nobody drives it
// Notes:   the device end wins if both drive a data line
interface sfp_if;
  logic sck;
  logic cs_n;
  logic restart_n;
  logic [3:0] h_out;
  logic [3:0] h_oe;
  logic [3:0] d_out;
  logic [3:0] d_oe;
  logic [3:0] io;

  // ----------------------------------------------------------------
  // line resolution
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_line
    assign io[i] = d_oe[i] ? d_out[i] : (h_oe[i] ? h_out[i] : 1'b1);
  end

  modport dev (input sck, input cs_n, input restart_n, input io, output d_out, output d_oe);
  modport host (output sck, output cs_n, output restart_n, output h_out, output h_oe,
                input io);
endinterface : sfp_if

// [verilog/sfp_sync.sv]
// Purpose: two-flop synchroniser for pins entering the system clock
// Assumes: inputs idle high
// Notes:   only the second flop is visible outside
module sfp_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,          // system clock
  input wire logic i_resetn,       // async reset, active low
  input wire logic i_ce,           // clock enable
  input wire logic [W-1:0] i_d,    // asynchronous inputs
  output logic [W-1:0] o_q         // synchronised outputs
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // two flops in series, reset to the idle-high level
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= '1;
      q_r <= '1;
    end else if (i_ce) begin
      meta_r <= i_d;
      q_r <= meta_r;
    end
  end

  assign o_q = q_r;
endmodule : sfp_sync

// [verilog/sfp_device.sv]
// Purpose: flash-side pin function logic: select, lanes, guard, pause, restart
// Assumes: link clock far slower than i_clk; all pins sampled by two flops
// Notes:   small own opcode set reaches status, function and read-param bits
// Operation
// - deselected means all outputs released
// - deselected means standby, select wakes it
// - ignore link bits while deselected
// - first instruction only after select falls
// - single-line input sampled on rising clock
// - single-line output changes on falling clock
// - dual/quad lines bidirectional, same edges
// - quad uses protect and pause pins
// - guard plus low protect pin blocks status
// - guard clear lets status writes through
// - quad enable disables protect pin function
// - quad enable disables pause and pin reset
// - no dedicated reset: select bit picks role
// - dedicated reset enabled: fourth pin pauses
// - dedicated reset disabled: select bit picks role
// - pause freezes sequence, releases output
// - sequence resumes where pause left it
// - restart low holds reset, outputs released
// - restart aborts internal write
// - function bit 0 disables dedicated restart
// - both clock idle levels work; idle high drops the last rising edge, which meets the deselect
// - four-lane command mode uses all lines
//
// Register access over APB and the placing of the registers were chosen for this implementation.
module sfp_device import sfp_pkg::*; #(
  parameter bit HAS_DED_RESET = 1'b1
) (
  input wire logic i_clk,          // system clock
  input wire logic i_resetn,       // async reset, active low
  input wire logic i_ce,           // clock enable, freezes all state
  sfp_if.dev link,                 // flash pins
  output logic [7:0] o_status,     // status register
  output logic o_standby,          // deselected, in standby
  output logic o_in_reset,         // held in reset by a pin
  output logic o_four_lane         // four-lane command mode
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [6:0] sync_q;
  logic s_sck;
  logic s_cs_n;
  logic s_rst_n;
  logic [3:0] s_io;
  logic sck_prev_r;
  logic rise;
  logic fall;

  sfp_sync #(.W(7)) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_d({link.io, link.restart_n, link.cs_n, link.sck}),
    .o_q(sync_q)
  );
  assign {s_io, s_rst_n, s_cs_n, s_sck} = sync_q;

  // edges found the same way for either idle level
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_prev_r <= 1'b0;
    end else if (i_ce) begin
      sck_prev_r <= s_sck;
    end
  end
  assign rise = s_sck & ~sck_prev_r;
  assign fall = ~s_sck & sck_prev_r;

  // ----------------------------------------------------------------
  // pin roles
  // ----------------------------------------------------------------
  logic [7:0] status_r;
  logic [7:0] func_r;
  logic [7:0] rdparam_r;
  logic qpi_r;
  logic quad_pins;
  logic ded_en;
  logic pin3_reset;
  logic pin3_pause;
  logic in_reset;
  logic hold;

  assign quad_pins = status_r[ST_QUAD] | qpi_r;
  assign ded_en = HAS_DED_RESET & ~func_r[FN_DED_RST_DIS];
  // fourth pin is a reset only when no enabled dedicated pin exists
  assign pin3_reset = ~quad_pins & ~ded_en & rdparam_r[RP_PAUSE_RESTART];
  assign pin3_pause = ~quad_pins & ~pin3_reset;
  assign in_reset = (ded_en & ~s_rst_n) | (pin3_reset & ~s_io[3]);
  assign hold = pin3_pause & ~s_io[3] & ~s_cs_n;

  // ----------------------------------------------------------------
  // instruction sequencer
  // ----------------------------------------------------------------
  sfp_dev_state_e state_r;
  logic armed_r;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] opc_r;
  logic [1:0] rdw_r;
  logic step;
  logic wr_fire;

  assign rx_nxt = qpi_r ? {rx_r[3:0], s_io} : {rx_r[6:0], s_io[0]};
  assign cnt_nxt = cnt_r + (qpi_r ? 4'h4 : 4'h1);
  // a rising edge counts only while selected, awake and not paused
  assign step = rise & ~s_cs_n & ~in_reset & ~hold & armed_r;
  assign wr_fire = step & (state_r == DV_WDATA) & (cnt_nxt == 4'h8);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= DV_IDLE;
      armed_r <= 1'b0;
      rx_r <= 8'h00;
      cnt_r <= 4'h0;
      opc_r <= 8'h00;
      rdw_r <= LN_1;
      qpi_r <= 1'b0;
    end else if (i_ce) begin
      if (in_reset) begin
        state_r <= DV_IDLE;
        cnt_r <= 4'h0;
      end else if (s_cs_n) begin
        state_r <= DV_IDLE;
        cnt_r <= 4'h0;
        armed_r <= 1'b1;
      end else if (state_r == DV_IDLE) begin
        // select seen low without a prior high level stays ignored
        if (armed_r) begin
          state_r <= DV_OPC;
        end
      end else if (step) begin
        if (state_r == DV_OPC || state_r == DV_WDATA) begin
          rx_r <= rx_nxt;
          cnt_r <= cnt_nxt;
        end
        if (state_r == DV_OPC && cnt_nxt == 4'h8) begin
          opc_r <= rx_nxt;
          cnt_r <= 4'h0;
          state_r <= DV_DROP;
          case (rx_nxt)
            OPC_RD_STATUS: begin
              state_r <= DV_READ;
              rdw_r <= qpi_r ? LN_4 : LN_1;
            end
            OPC_RD_STATUS_DUAL: begin
              state_r <= DV_READ;
              rdw_r <= qpi_r ? LN_4 : LN_2;
            end
            OPC_RD_STATUS_QUAD: begin
              if (quad_pins) begin
                state_r <= DV_READ;
                rdw_r <= LN_4;
              end
            end
            OPC_WR_STATUS, OPC_WR_FUNC, OPC_WR_RDPARAM: begin
              state_r <= DV_WDATA;
            end
            OPC_QPI_ENTER: begin
              qpi_r <= status_r[ST_QUAD];
            end
            OPC_QPI_EXIT: begin
              qpi_r <= 1'b0;
            end
            default: begin
              state_r <= DV_DROP;
            end
          endcase
        end else if (wr_fire) begin
          state_r <= DV_DROP;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers and internal write timer
  // ----------------------------------------------------------------
  logic [WCW-1:0] busy_cnt_r;
  logic guarded;

  // protect pin counts only while it is not a data line
  assign guarded = status_r[ST_GUARD] & ~s_io[2] & ~quad_pins;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_r <= STATUS_RST;
      func_r <= FUNC_RST;
      rdparam_r <= RDPARAM_RST;
      busy_cnt_r <= '0;
    end else if (i_ce) begin
      if (in_reset) begin
        busy_cnt_r <= '0;
        status_r[ST_BUSY] <= 1'b0;
      end else if (wr_fire) begin
        if (opc_r == OPC_WR_STATUS) begin
          if (!guarded) begin
            status_r[7:ST_PROT_LO] <= rx_nxt[7:ST_PROT_LO];
          end
          status_r[ST_BUSY] <= 1'b1;
          busy_cnt_r <= WCW'(WRITE_CYC);
        end else if (opc_r == OPC_WR_FUNC) begin
          func_r <= rx_nxt;
        end else begin
          rdparam_r <= rx_nxt;
        end
      end else if (busy_cnt_r != '0) begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
        if (busy_cnt_r == WCW'(1)) begin
          status_r[ST_BUSY] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // output lanes
  // ----------------------------------------------------------------
  logic [7:0] tx_r;
  logic [3:0] txc_r;
  logic drive_r;
  logic [3:0] d_out_r;
  logic [3:0] d_oe_r;
  logic [3:0] mask;

  always_comb begin
    case (rdw_r)
      LN_2: mask = 4'h3;
      LN_4: mask = 4'hf;
      default: mask = 4'h2;
    endcase
  end

  // data moves only on falling edges; status reloads every byte
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_r <= 8'h00;
      txc_r <= 4'h0;
      drive_r <= 1'b0;
      d_out_r <= 4'h0;
    end else if (i_ce) begin
      if (state_r != DV_READ || s_cs_n || in_reset) begin
        tx_r <= status_r;
        txc_r <= 4'h0;
        drive_r <= 1'b0;
      end else if (fall && !hold) begin
        drive_r <= 1'b1;
        case (rdw_r)
          LN_2: begin
            d_out_r <= {2'b00, tx_r[7:6]};
            tx_r <= {tx_r[5:0], 2'b00};
            txc_r <= txc_r + 4'h2;
          end
          LN_4: begin
            d_out_r <= tx_r[7:4];
            tx_r <= {tx_r[3:0], 4'h0};
            txc_r <= txc_r + 4'h4;
          end
          default: begin
            d_out_r <= {2'b00, tx_r[7], 1'b0};
            tx_r <= {tx_r[6:0], 1'b0};
            txc_r <= txc_r + 4'h1;
          end
        endcase
        if (txc_r == 4'h8) begin
          tx_r <= status_r;
          txc_r <= 4'h0;
        end
      end
    end
  end

  // released lines whenever deselected, paused or in reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      d_oe_r <= 4'h0;
    end else if (i_ce) begin
      if (s_cs_n || hold || in_reset || state_r != DV_READ || !drive_r) begin
        d_oe_r <= 4'h0;
      end else begin
        d_oe_r <= mask;
      end
    end
  end

  // ----------------------------------------------------------------
  // user-side flags
  // ----------------------------------------------------------------
  logic standby_r;
  logic in_reset_r;

  // standby gates nothing here beyond the sequencer and the output lanes, kept as a flag
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      standby_r <= 1'b1;
      in_reset_r <= 1'b0;
    end else if (i_ce) begin
      standby_r <= s_cs_n;
      in_reset_r <= in_reset;
    end
  end

  assign link.d_out = d_out_r;
  assign link.d_oe = d_oe_r;
  assign o_status = status_r;
  assign o_standby = standby_r;
  assign o_in_reset = in_reset_r;
  assign o_four_lane = qpi_r;
endmodule : sfp_device

// [verilog/sfp_host.sv]
// Purpose: spi master controller driving the flash pins, apb register port
// Assumes: apb clock is i_clk
// Notes:   one command per write to the command register
module sfp_host import sfp_pkg::*; (
  input wire logic i_clk,          // system clock
  input wire logic i_resetn,       // async reset, active low
  input wire logic i_ce,           // clock enable, freezes all state
  input wire logic i_psel,         // apb select
  input wire logic i_penable,      // apb enable
  input wire logic i_pwrite,       // apb direction
  input wire logic [7:0] i_paddr,  // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata,    // apb read data
  output logic o_pready,           // apb ready
  output logic o_pslverr,          // apb error, unmapped address
  sfp_if.host link                 // flash pins
);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [3:0] ctrl_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic acc;
  logic start;
  logic [7:0] rx_r;
  sfp_host_state_e st_r;

  assign acc = i_psel & i_penable & pready_r;
  // a command written while busy is dropped
  assign start = acc & i_pwrite & (i_paddr == REG_CMD) & (st_r == HS_IDLE);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      ctrl_r <= CTRL_RST;
    end else if (i_ce) begin
      if (i_psel && !i_penable) begin
        pready_r <= 1'b1;
        pslverr_r <= 1'b0;
        prdata_r <= 32'h0;
        if (i_paddr == REG_CTRL) begin
          prdata_r <= {28'h0, ctrl_r};
        end else if (i_paddr == REG_STAT) begin
          prdata_r <= {16'h0, rx_r, 7'h0, st_r == HS_RUN};
        end else if (i_paddr != REG_CMD) begin
          pslverr_r <= 1'b1;
        end
      end else if (acc) begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        if (i_pwrite && i_paddr == REG_CTRL) begin
          ctrl_r <= i_pwdata[3:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  logic [3:0] s_io;
  logic [3:0] div_r;
  logic [4:0] clk_cnt_r;
  logic [4:0] send_clks_r;
  logic [4:0] all_clks_r;
  logic [15:0] tx_r;
  logic ow4_r;
  logic [1:0] rdw_r;
  logic sending_r;
  logic sck_r;
  logic cs_n_r;
  logic [4:0] opc_clks;
  logic [4:0] rd_clks;

  sfp_sync #(.W(4)) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_d(link.io),
    .o_q(s_io)
  );

  assign opc_clks = i_pwdata[CMD_QPI] ? 5'd2 : 5'd8;
  always_comb begin
    case (i_pwdata[CMD_RDW_LO +: 2])
      LN_2: rd_clks = 5'd4;
      LN_4: rd_clks = 5'd2;
      default: rd_clks = 5'd8;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= HS_IDLE;
      div_r <= 4'h0;
      clk_cnt_r <= 5'd0;
      send_clks_r <= 5'd0;
      all_clks_r <= 5'd0;
      tx_r <= 16'h0;
      ow4_r <= 1'b0;
      rdw_r <= LN_1;
      sending_r <= 1'b0;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      rx_r <= 8'h00;
    end else if (i_ce) begin
      if (st_r == HS_IDLE) begin
        sck_r <= ctrl_r[CTL_CPOL];
        if (start) begin
          st_r <= HS_RUN;
          cs_n_r <= 1'b0;
          div_r <= 4'h0;
          clk_cnt_r <= 5'd0;
          tx_r <= {i_pwdata[CMD_OPC_LO +: 8], i_pwdata[CMD_WD_LO +: 8]};
          ow4_r <= i_pwdata[CMD_QPI];
          rdw_r <= i_pwdata[CMD_RDW_LO +: 2];
          sending_r <= 1'b1;
          if (i_pwdata[CMD_KIND_LO +: 2] == KIND_WR) begin
            send_clks_r <= 5'(opc_clks << 1);
            all_clks_r <= 5'(opc_clks << 1);
          end else if (i_pwdata[CMD_KIND_LO +: 2] == KIND_RD) begin
            send_clks_r <= opc_clks;
            all_clks_r <= 5'(opc_clks + rd_clks);
          end else begin
            send_clks_r <= opc_clks;
            all_clks_r <= opc_clks;
          end
        end
      end else if (div_r != 4'(SCK_HALF_CYC - 1)) begin
        div_r <= div_r + 4'h1;
      end else begin
        div_r <= 4'h0;
        sck_r <= ~sck_r;
        if (!sck_r) begin
          // rising edge: device samples, host samples read lanes
          clk_cnt_r <= clk_cnt_r + 5'd1;
          if (clk_cnt_r >= send_clks_r) begin
            case (rdw_r)
              LN_2: rx_r <= {rx_r[5:0], s_io[1:0]};
              LN_4: rx_r <= {rx_r[3:0], s_io};
              default: rx_r <= {rx_r[6:0], s_io[1]};
            endcase
          end
          if (clk_cnt_r + 5'd1 == all_clks_r && ctrl_r[CTL_CPOL]) begin
            st_r <= HS_IDLE;
            cs_n_r <= 1'b1;
            sending_r <= 1'b0;
          end
        end else if (clk_cnt_r == all_clks_r && clk_cnt_r != 5'd0) begin
          st_r <= HS_IDLE;
          cs_n_r <= 1'b1;
          sending_r <= 1'b0;
        end else if (clk_cnt_r != 5'd0) begin
          // falling edge: next bits out, or release for the read
          tx_r <= ow4_r ? {tx_r[11:0], 4'h0} : {tx_r[14:0], 1'b0};
          if (clk_cnt_r == send_clks_r) begin
            sending_r <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [3:0] h_out_r;
  logic [3:0] h_oe_r;
  logic restart_r;
  logic quad_use;

  // upper pins carry protect and pause levels unless used as lanes
  assign quad_use = (st_r == HS_RUN) & (ow4_r | rdw_r == LN_4);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      h_out_r <= 4'hc;
      h_oe_r <= 4'hc;
      restart_r <= 1'b1;
    end else if (i_ce) begin
      restart_r <= ctrl_r[CTL_RESTART];
      h_out_r <= {ctrl_r[CTL_PAUSE], ctrl_r[CTL_WP], 2'b00};
      h_oe_r <= 4'hc;
      if (quad_use) begin
        h_oe_r <= 4'h0;
      end
      if (sending_r && ow4_r) begin
        h_out_r <= tx_r[15:12];
        h_oe_r <= 4'hf;
      end else if (sending_r) begin
        h_out_r[0] <= tx_r[15];
        h_oe_r[0] <= 1'b1;
      end
    end
  end

  assign link.sck = sck_r;
  assign link.cs_n = cs_n_r;
  assign link.restart_n = restart_r;
  assign link.h_out = h_out_r;
  assign link.h_oe = h_oe_r;
  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
endmodule : sfp_host

// [verification/sfp_link_checker.sv]
// Purpose: wire checks on the flash link, device end
// Assumes: i_clk far faster than sck
// Notes: host enables seen only to catch clashes
module sfp_link_checker (
  input wire logic i_clk,       // system clock
  input wire logic i_resetn,    // async reset, active low
  input wire logic sck,         // link clock
  input wire logic cs_n,        // select
  input wire logic restart_n,   // dedicated restart
  input wire logic [3:0] h_oe,  // host enables
  input wire logic [3:0] d_out, // device data
  input wire logic [3:0] d_oe   // device enables
);
  // ----
  // device pin rules
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  desel_quiet_a: assert property (cs_n [*6] |-> d_oe == 4'h0)
    else $error("device drives while deselected");
  desel_release_a: assert property ($rose(cs_n) |-> ##[1:5] d_oe == 4'h0)
    else $error("device kept lines after deselect");
  restart_quiet_a: assert property (restart_n == 1'b0 [*6] |-> d_oe == 4'h0)
    else $error("device drives in restart");
  fall_edge_a: assert property (!cs_n && d_oe != 4'h0 && $past(d_oe) != 4'h0
    && $changed(d_out & d_oe) |-> !sck)
    else $error("output changed with clock high");
  drive_start_a: assert property (d_oe != 4'h0 && $past(d_oe) == 4'h0 |-> !sck && !cs_n)
    else $error("output enabled at wrong time");
  lane_set_a: assert property (d_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal lane enable set");
  no_clash_a: assert property ((h_oe & d_oe & 4'h3) == 4'h0)
    else $error("both ends drive a data line");
  reset_quiet_a: assert property ($rose(i_resetn) |-> (d_oe == 4'h0) [*8])
    else $error("device drives after reset");
endmodule : sfp_link_checker

// [verification/serial_flash_pin_function_control_bench.sv]
// Purpose: host and device joined, driven over apb
// Assumes: device answers inside a command
// Notes: pause resume not exercised; function register only written once, in t_pins
module serial_flash_pin_function_control_bench;
  import sfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_resetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, standby, in_reset, four_lane;
  logic [7:0] status;
  int fails = 0, total_checks = 0;
  sfp_if lnk();
  sfp_host i_sfp_host (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(lnk.host));
  sfp_device i_sfp_device (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1), .link(lnk.dev),
    .o_status(status), .o_standby(standby), .o_in_reset(in_reset), .o_four_lane(four_lane));
  sfp_link_checker i_sfp_link_checker (.i_clk(i_clk), .i_resetn(i_resetn), .sck(lnk.sck),
    .cs_n(lnk.cs_n), .restart_n(lnk.restart_n), .h_oe(lnk.h_oe), .d_out(lnk.d_out),
    .d_oe(lnk.d_oe));
  // ----
  // clock and helpers
  // ----
  always #20 i_clk = ~i_clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // request held until pready seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // look at the answer while it stands, then complete on the next rising edge
    do @(negedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    @(posedge i_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // busy is set on the write's own closing edge; two idle cycles pass before polling
  task automatic cmd(input logic [7:0] op, wb, input logic [1:0] k, ln, input logic q);
    apb(1'b1, REG_CMD, {11'h0, q, ln, k, wb, op});
    repeat (2) @(posedge i_clk);
    do apb(1'b0, REG_STAT, 32'h0); while (rd[STAT_BUSY] !== 1'b0);
  endtask : cmd
  task automatic rdst(input logic [7:0] op, input logic [1:0] ln, input logic q,
                      input logic [7:0] e);
    cmd(op, 8'h00, KIND_RD, ln, q);
    chk("read byte", {24'h0, e}, {24'h0, rd[15:8]});
  endtask : rdst
  task automatic wrst(input logic [7:0] v);
    cmd(OPC_WR_STATUS, v, KIND_WR, LN_1, 1'b0);
  endtask : wrst
  task automatic stop_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", {28'h0, CTRL_RST}, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("slverr", 1, er);
    chk("standby", 1, standby);
    rdst(OPC_RD_STATUS, LN_1, 1'b0, STATUS_RST);
  endtask : t_regs
  task automatic t_guard;
    wrst(8'h80);
    rdst(OPC_RD_STATUS, LN_1, 1'b0, 8'h80);
    apb(1'b1, REG_CTRL, 32'hd);
    wrst(8'hbc);
    rdst(OPC_RD_STATUS_DUAL, LN_2, 1'b0, 8'h80);
    apb(1'b1, REG_CTRL, 32'he);
    wrst(8'h40);
    rdst(OPC_RD_STATUS_QUAD, LN_4, 1'b0, 8'h40);
  endtask : t_guard
  task automatic t_quad;
    apb(1'b1, REG_CTRL, 32'hc);
    wrst(8'hc0);
    wrst(8'h44);
    rdst(OPC_RD_STATUS, LN_1, 1'b0, 8'h44);
    apb(1'b1, REG_CTRL, 32'ha);
    rdst(OPC_RD_STATUS, LN_1, 1'b0, 8'h44);
    cmd(OPC_QPI_ENTER, 8'h00, KIND_OPC, LN_1, 1'b0);
    chk("four lane", 1, four_lane);
    rdst(OPC_RD_STATUS_QUAD, LN_4, 1'b1, 8'h44);
    cmd(OPC_QPI_EXIT, 8'h00, KIND_OPC, LN_4, 1'b1);
    chk("four lane", 0, four_lane);
  endtask : t_quad
  // pause held low with quad off: reply line floats to pull-up
  task automatic t_pins;
    apb(1'b1, REG_CTRL, 32'he);
    wrst(8'h3c);
    apb(1'b1, REG_CTRL, 32'ha);
    rdst(OPC_RD_STATUS, LN_1, 1'b0, 8'hff);
    apb(1'b1, REG_CTRL, 32'h6);
    repeat (6) @(posedge i_clk);
    chk("in reset", 1, in_reset);
    apb(1'b1, REG_CTRL, 32'he);
    repeat (6) @(posedge i_clk);
    chk("in reset", 0, in_reset);
    rdst(OPC_RD_STATUS, LN_1, 1'b0, 8'h3c);
    chk("status", 32'h3c, {24'h0, status});
    cmd(OPC_WR_FUNC, 8'h01, KIND_WR, LN_1, 1'b0);
    apb(1'b1, REG_CTRL, 32'h6);
    repeat (6) @(posedge i_clk);
    chk("in reset", 0, in_reset);
    cmd(OPC_WR_RDPARAM, 8'h80, KIND_WR, LN_1, 1'b0);
    apb(1'b1, REG_CTRL, 32'ha);
    repeat (6) @(posedge i_clk);
    chk("in reset", 1, in_reset);
    apb(1'b1, REG_CTRL, 32'he);
  endtask : t_pins
  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_regs();
    t_guard();
    t_quad();
    t_pins();
    stop_test();
  end
  // watchdog: each command is well under 20 us
  initial begin
    #1000000;
    fails++;
    stop_test();
  end
endmodule : serial_flash_pin_function_control_bench
